// [adc_ctrl_regs.sv]
// serial control port, register bank and decoded settings of the converter
// Function
// RQ1 - format code selects framing, resets to I2S
// RQ2 - polarity bit inverts frame, or DSP phase
// RQ3 - edge bit picks rising or falling bit edge
// RQ4 - word length code gives 16/20/24 bits; code 3 gives 32 bits here
// RQ5 - ratio code sets master clock to frame ratio
// RQ6 - master bit makes frame and bit clocks outputs
// RQ7 - powerdown bits stop chip or input buffer
// RQ8 - per-channel gain code, zero-cross enable bit
// RQ9 - threshold code spans -16 to -1 dBFS
// RQ10 - ceiling code caps gain, 4dB steps
// RQ11 - select code picks limiter or AUTOMATIC_LEVEL_CONTROL channels
// RQ12 - hold code delays gain rise, doubling steps
// RQ13 - gain control runs only when enabled
// RQ14 - attack code sets ramp-down time, doubling
// RQ15 - decay code sets ramp-up time, doubling
// RQ16 - noise gate enable and threshold, AUTOMATIC_LEVEL_CONTROL only
// RQ17 - attenuation floor differs per mode
// RQ18 - transient window delays limiter response
// RQ19 - mix code routes input pairs, resets pair 1
// RQ20 - mute bits silence their channel
// RQ21 - write-both loads gain into both channels
// RQ22 - reset register write restores all defaults
// RQ23 - several mix bits sum their pairs
// RQ24 - buffer powerdown switches inputs to midrail
// RQ25 - triggered noise gate holds gain constant
// RQ26 - software writes zero to reserved bits
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_regs
	import adc_ctrl_pkg::*;
#(
	parameter int HOLD_CYCLES = HOLD_BASE_CYCLES,
	parameter int ATTACK_ALC_BASE = ATTACK_ALC_CYCLES,
	parameter int ATTACK_LIM_BASE = ATTACK_LIM_CYCLES,
	parameter int DECAY_ALC_BASE = DECAY_ALC_CYCLES,
	parameter int DECAY_LIM_BASE = DECAY_LIM_CYCLES
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// serial control pins
	input wire logic ctl_clock_pin,
	input wire logic ctl_data_pin,
	input wire logic ctl_latch_pin,
	// level detector
	input wire logic noise_gate_triggered,
	// settings to the audio path
	output audio_settings_t settings,
	output logic [31:0] hold_cycles,
	output logic [31:0] attack_cycles,
	output logic [31:0] decay_cycles,
	output logic [31:0] transient_cycles,
	output logic zero_cross_timeout_disable
);

	logic rst_meta_reg;
	logic rst_n_reg;
	logic [2:0] sync_reg [3];
	logic [2:0] pin_reg;
	logic [2:0] pin_prev_reg;
	logic [15:0] shift_reg;
	logic [4:0] count_reg;
	logic [8:0] bank_reg [NUM_REGS];
	logic [2:0] pin_raw;
	logic clock_rise;
	logic latch_rise;
	logic latch_fall;
	logic frame_done;
	logic [6:0] wr_addr;
	logic [8:0] wr_data;
	logic soft_reset;
	logic gain_both;
	audio_if_reg_t r_if;
	master_clk_reg_t r_mclk;
	power_reg_t r_pd;
	gain_reg_t r_lg;
	gain_reg_t r_rg;
	level_one_reg_t r_lc1;
	level_two_reg_t r_lc2;
	level_three_reg_t r_lc3;
	noise_gate_reg_t r_ng;
	limiter_reg_t r_lim;
	mixer_reg_t r_mix;
	zero_cross_reg_t r_zc;
	audio_settings_t settings_next;
	logic [31:0] hold_next;
	logic [31:0] attack_next;
	logic [31:0] decay_next;
	logic [31:0] transient_next;

	// doubling time from a base, clamped at the saturating code
	function automatic logic [31:0] doubling_time(input logic [31:0] base, input logic [3:0] code);
		logic [3:0] eff;
		eff = (code > TIME_CODE_SAT) ? TIME_CODE_SAT : code;
		return base << eff;
	endfunction : doubling_time

	always_ff @(posedge clk_sys or negedge rst_b) begin
		if (!rst_b) begin
			rst_meta_reg <= 1'b0;
			rst_n_reg <= 1'b0;
		end else begin
			rst_meta_reg <= 1'b1;
			rst_n_reg <= rst_meta_reg;
		end
	end

	// pins are asynchronous; a level counts once the last two stages agree
	assign pin_raw = {ctl_latch_pin, ctl_data_pin, ctl_clock_pin};

	generate
		for (genvar p = 0; p < 3; p++) begin : g_pin
			always_ff @(posedge clk_sys or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					// latch idles high; resetting it low would fake a latch edge
					sync_reg[p] <= (p == 2) ? 3'h7 : 3'h0;
					pin_reg[p] <= (p == 2);
				end else begin
					sync_reg[p] <= {sync_reg[p][1:0], pin_raw[p]};
					if (sync_reg[p][1] == sync_reg[p][2]) begin
						pin_reg[p] <= sync_reg[p][2];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			pin_prev_reg <= 3'h4;
		end else begin
			pin_prev_reg <= pin_reg;
		end
	end

	assign clock_rise = pin_reg[0] & ~pin_prev_reg[0];
	assign latch_rise = pin_reg[2] & ~pin_prev_reg[2];
	assign latch_fall = ~pin_reg[2] & pin_prev_reg[2];

	// bits shift in while the latch is low; frames of other lengths are dropped
	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			shift_reg <= 16'h0000;
			count_reg <= 5'h00;
		end else if (latch_fall || latch_rise) begin
			count_reg <= 5'h00;
		end else if (clock_rise && !pin_reg[2]) begin
			shift_reg <= {shift_reg[14:0], pin_reg[1]};
			if (count_reg <= FRAME_BITS) begin
				count_reg <= count_reg + 5'h01;
			end
		end
	end

	assign frame_done = latch_rise && (count_reg == FRAME_BITS);
	assign wr_addr = shift_reg[15:9];
	assign wr_data = shift_reg[8:0];
	assign soft_reset = frame_done && (wr_addr == ADDR_REGISTER_RESET); // RQ22
	assign gain_both = bank_reg[IDX_MIX][8];

	generate
		for (genvar i = 0; i < NUM_REGS; i++) begin : g_bank
			always_ff @(posedge clk_sys or negedge rst_n_reg) begin
				if (!rst_n_reg) begin
					bank_reg[i] <= REG_DEFAULT[i];
				end else if (soft_reset) begin
					bank_reg[i] <= REG_DEFAULT[i]; // RQ22
				end else if (frame_done && wr_addr == REG_OFFSET[i]) begin
					bank_reg[i] <= wr_data;
				end else if (frame_done && gain_both && (i == IDX_LG || i == IDX_RG)
					&& (wr_addr == ADDR_LEFT_GAIN || wr_addr == ADDR_RIGHT_GAIN)) begin
					// the other channel takes the code only; its zero-cross bit stays
					bank_reg[i][7:0] <= wr_data[7:0]; // RQ21
				end
			end
		end
	endgenerate

	assign r_zc = zero_cross_reg_t'(bank_reg[IDX_ZC]);
	assign r_if = audio_if_reg_t'(bank_reg[IDX_IF]);
	assign r_mclk = master_clk_reg_t'(bank_reg[IDX_MCLK]);
	assign r_pd = power_reg_t'(bank_reg[IDX_PD]);
	assign r_lg = gain_reg_t'(bank_reg[IDX_LG]);
	assign r_rg = gain_reg_t'(bank_reg[IDX_RG]);
	assign r_lc1 = level_one_reg_t'(bank_reg[IDX_LC1]);
	assign r_lc2 = level_two_reg_t'(bank_reg[IDX_LC2]);
	assign r_lc3 = level_three_reg_t'(bank_reg[IDX_LC3]);
	assign r_ng = noise_gate_reg_t'(bank_reg[IDX_NG]);
	assign r_lim = limiter_reg_t'(bank_reg[IDX_LIM]);
	assign r_mix = mixer_reg_t'(bank_reg[IDX_MIX]);

	// audio interface, clocking and power
	always_comb begin
		settings_next = '0;
		settings_next.audio_format = r_if.audio_format_select; // RQ1
		if (r_if.audio_format_select == FMT_DSP) begin
			settings_next.dsp_late = r_if.frame_polarity_or_dsp_phase; // RQ2
		end else begin
			settings_next.frame_invert = r_if.frame_polarity_or_dsp_phase; // RQ2
		end
		settings_next.sample_on_falling = r_if.bit_clock_edge_select; // RQ3
		case (r_if.sample_word_length) // RQ4
			2'h0: settings_next.word_bits = 6'h10;
			2'h1: settings_next.word_bits = 6'h14;
			2'h2: settings_next.word_bits = 6'h18;
			default: settings_next.word_bits = 6'h20;
		endcase
		case (r_mclk.master_clock_ratio) // RQ5
			3'h2: settings_next.mclk_ratio = 10'h100;
			3'h3: settings_next.mclk_ratio = 10'h180;
			3'h4: settings_next.mclk_ratio = 10'h200;
			3'h5: settings_next.mclk_ratio = 10'h300;
			default: settings_next.mclk_ratio = 10'h000;
		endcase
		settings_next.frame_clock_oe = r_mclk.master_slave_select; // RQ6
		settings_next.bit_clock_oe = r_mclk.master_slave_select; // RQ6
		settings_next.all_powered_down = r_pd.chip_powerdown; // RQ7
		settings_next.mux_to_midrail = r_pd.input_buffer_powerdown; // RQ7 RQ24
		// each mix bit adds its pair; all pairs drop out onto midrail when buffered down
		settings_next.input_route = r_pd.input_buffer_powerdown ? 4'h0
			: r_mix.input_mix_select; // RQ19 RQ23 RQ24
		settings_next.left_gain_code = r_lg.gain_code; // RQ8
		settings_next.right_gain_code = r_rg.gain_code; // RQ8
		settings_next.left_zero_cross = r_lg.zero_cross_enable; // RQ8
		settings_next.right_zero_cross = r_rg.zero_cross_enable; // RQ8
		settings_next.left_mute = r_mix.left_mute; // RQ20
		settings_next.right_mute = r_mix.right_mute; // RQ20

		// level control
		settings_next.gain_control_run = r_lc2.gain_control_enable; // RQ13
		settings_next.level_zero_cross = r_lc2.gain_control_enable
			& r_lc2.level_zero_cross_use; // RQ13
		settings_next.limiter_mode = (r_lc1.level_control_select == SEL_LIMITER); // RQ11
		settings_next.alc_right = r_lc2.gain_control_enable
			& r_lc1.level_control_select[0]; // RQ11
		settings_next.alc_left = r_lc2.gain_control_enable
			& r_lc1.level_control_select[1]; // RQ11
		settings_next.threshold_db = 8'(signed'({4'h0, r_lc1.level_threshold})) - 8'sd16; // RQ9
		if (r_lc1.gain_ceiling <= 3'h1) begin
			settings_next.ceiling_db = 8'sd0; // RQ10
		end else begin
			settings_next.ceiling_db = 8'(signed'({5'h00, r_lc1.gain_ceiling} - 8'h01) * 4); // RQ10
		end
		if (settings_next.limiter_mode) begin
			if (r_lim.attenuation_floor <= 4'h3) begin
				settings_next.floor_db = -8'sd3; // RQ17
			end else if (r_lim.attenuation_floor >= 4'hc) begin
				settings_next.floor_db = -8'sd12; // RQ17
			end else begin
				settings_next.floor_db = -8'(signed'({4'h0, r_lim.attenuation_floor})); // RQ17
			end
		end else if (r_lim.attenuation_floor <= 4'ha) begin
			settings_next.floor_db = -8'sd1; // RQ17
		end else begin
			settings_next.floor_db = -8'sd5
				- 8'(signed'({4'h0, r_lim.attenuation_floor} - 8'h0b) * 4); // RQ17
		end
		settings_next.noise_gate_db = -8'sd78
			+ 8'(signed'({5'h00, r_ng.noise_gate_threshold}) * 6); // RQ16
		// the gate runs only while gain control is enabled, for any of the three ALC channel selections, and is off for the limiter
		settings_next.noise_gate_active = r_ng.noise_gate_enable
			& r_lc2.gain_control_enable & ~settings_next.limiter_mode; // RQ16
		settings_next.gain_hold = settings_next.noise_gate_active
			& noise_gate_triggered; // RQ25
	end

	// time codes turned into clock cycles
	always_comb begin
		hold_next = (r_lc2.hold_time_code == 4'h0) ? 32'h0
			: 32'(HOLD_CYCLES) << (r_lc2.hold_time_code - 4'h1); // RQ12
		if (r_lc1.level_control_select == SEL_LIMITER) begin
			attack_next = doubling_time(32'(ATTACK_LIM_BASE), r_lc3.attack_time_code); // RQ14
			decay_next = doubling_time(32'(DECAY_LIM_BASE), r_lc3.decay_time_code); // RQ15
			transient_next = (r_lim.transient_window == 3'h0) ? 32'h0
				: TRANSIENT_BASE_CYCLES << (r_lim.transient_window - 3'h1); // RQ18
		end else begin
			attack_next = doubling_time(32'(ATTACK_ALC_BASE), r_lc3.attack_time_code); // RQ14
			decay_next = doubling_time(32'(DECAY_ALC_BASE), r_lc3.decay_time_code); // RQ15
			// the window only guards the limiter
			transient_next = 32'h0; // RQ18
		end
	end

	always_ff @(posedge clk_sys or negedge rst_n_reg) begin
		if (!rst_n_reg) begin
			settings <= '0;
			hold_cycles <= 32'h0;
			attack_cycles <= 32'h0;
			decay_cycles <= 32'h0;
			transient_cycles <= 32'h0;
			zero_cross_timeout_disable <= 1'b0;
		end else begin
			settings <= settings_next;
			hold_cycles <= hold_next;
			attack_cycles <= attack_next;
			decay_cycles <= decay_next;
			transient_cycles <= transient_next;
			zero_cross_timeout_disable <= r_zc.timeout_disable;
		end
	end

endmodule : adc_ctrl_regs
`default_nettype wire

// [adc_ctrl_pkg.sv]
// shared constants, register layouts and types of the converter control bank
package adc_ctrl_pkg;

	// serial control frame: 7-bit address then 9-bit data, msb first
	localparam int ADDR_BITS = 7;
	localparam int DATA_BITS = 9;
	localparam logic [4:0] FRAME_BITS = 5'h10;

	// register offsets
	localparam logic [6:0] ADDR_ZERO_CROSS_TIMEOUT = 7'h07;
	localparam logic [6:0] ADDR_AUDIO_INTERFACE = 7'h0b;
	localparam logic [6:0] ADDR_MASTER_CLOCKING = 7'h0c;
	localparam logic [6:0] ADDR_POWERDOWN = 7'h0d;
	localparam logic [6:0] ADDR_LEFT_GAIN = 7'h0e;
	localparam logic [6:0] ADDR_RIGHT_GAIN = 7'h0f;
	localparam logic [6:0] ADDR_LEVEL_ONE = 7'h10;
	localparam logic [6:0] ADDR_LEVEL_TWO = 7'h11;
	localparam logic [6:0] ADDR_LEVEL_THREE = 7'h12;
	localparam logic [6:0] ADDR_NOISE_GATE = 7'h13;
	localparam logic [6:0] ADDR_LIMITER = 7'h14;
	localparam logic [6:0] ADDR_INPUT_MIXER = 7'h15;
	localparam logic [6:0] ADDR_REGISTER_RESET = 7'h17;

	// storage index of each stored register
	localparam int NUM_REGS = 12;
	localparam int IDX_ZC = 0;
	localparam int IDX_IF = 1;
	localparam int IDX_MCLK = 2;
	localparam int IDX_PD = 3;
	localparam int IDX_LG = 4;
	localparam int IDX_RG = 5;
	localparam int IDX_LC1 = 6;
	localparam int IDX_LC2 = 7;
	localparam int IDX_LC3 = 8;
	localparam int IDX_NG = 9;
	localparam int IDX_LIM = 10;
	localparam int IDX_MIX = 11;

	localparam logic [6:0] REG_OFFSET [NUM_REGS] = '{
		ADDR_ZERO_CROSS_TIMEOUT, ADDR_AUDIO_INTERFACE, ADDR_MASTER_CLOCKING, ADDR_POWERDOWN,
		ADDR_LEFT_GAIN, ADDR_RIGHT_GAIN, ADDR_LEVEL_ONE, ADDR_LEVEL_TWO,
		ADDR_LEVEL_THREE, ADDR_NOISE_GATE, ADDR_LIMITER, ADDR_INPUT_MIXER};

	// values after reset
	localparam logic [8:0] REG_DEFAULT [NUM_REGS] = '{
		9'h000, 9'h022, 9'h022, 9'h000, 9'h0cf, 9'h0cf,
		9'h07b, 9'h000, 9'h032, 9'h000, 9'h0a6, 9'h001};

	typedef enum logic [1:0] {
		FMT_RIGHT_JUSTIFIED = 2'h0,
		FMT_LEFT_JUSTIFIED = 2'h1,
		FMT_I2S = 2'h2,
		FMT_DSP = 2'h3
	} audio_format_t;

	typedef enum logic [1:0] {
		SEL_LIMITER = 2'h0,
		SEL_ALC_RIGHT = 2'h1,
		SEL_ALC_LEFT = 2'h2,
		SEL_ALC_STEREO = 2'h3
	} level_select_t;

	// register layouts, bit 8 first
	typedef struct packed {
		logic [4:0] rsv_hi;
		logic timeout_disable;
		logic [2:0] rsv_lo;
	} zero_cross_reg_t;

	typedef struct packed {
		logic hpf_disable;
		logic rsv;
		logic master_clock_invert;
		logic [1:0] sample_word_length;
		logic bit_clock_edge_select;
		logic frame_polarity_or_dsp_phase;
		audio_format_t audio_format_select;
	} audio_if_reg_t;

	typedef struct packed {
		logic master_slave_select;
		logic [3:0] rsv;
		logic oversample_select;
		logic [2:0] master_clock_ratio;
	} master_clk_reg_t;

	typedef struct packed {
		logic [1:0] rsv_hi;
		logic input_buffer_powerdown;
		logic [3:0] rsv_lo;
		logic adc_powerdown;
		logic chip_powerdown;
	} power_reg_t;

	typedef struct packed {
		logic zero_cross_enable;
		logic [7:0] gain_code;
	} gain_reg_t;

	typedef struct packed {
		level_select_t level_control_select;
		logic [2:0] gain_ceiling;
		logic [3:0] level_threshold;
	} level_one_reg_t;

	typedef struct packed {
		logic gain_control_enable;
		logic level_zero_cross_use;
		logic [2:0] rsv;
		logic [3:0] hold_time_code;
	} level_two_reg_t;

	typedef struct packed {
		logic rsv;
		logic [3:0] decay_time_code;
		logic [3:0] attack_time_code;
	} level_three_reg_t;

	typedef struct packed {
		logic [3:0] rsv_hi;
		logic [2:0] noise_gate_threshold;
		logic rsv_lo;
		logic noise_gate_enable;
	} noise_gate_reg_t;

	typedef struct packed {
		logic [1:0] rsv;
		logic [2:0] transient_window;
		logic [3:0] attenuation_floor;
	} limiter_reg_t;

	typedef struct packed {
		logic gain_write_both;
		logic left_mute;
		logic right_mute;
		logic [1:0] rsv;
		logic [3:0] input_mix_select;
	} mixer_reg_t;

	// decoded settings presented to the audio path
	typedef struct packed {
		audio_format_t audio_format;
		logic frame_invert;
		logic dsp_late;
		logic sample_on_falling;
		logic [5:0] word_bits;
		logic [9:0] mclk_ratio;
		logic frame_clock_oe;
		logic bit_clock_oe;
		logic all_powered_down;
		logic mux_to_midrail;
		logic [3:0] input_route;
		logic [7:0] left_gain_code;
		logic [7:0] right_gain_code;
		logic left_zero_cross;
		logic right_zero_cross;
		logic left_mute;
		logic right_mute;
		logic gain_control_run;
		logic level_zero_cross;
		logic limiter_mode;
		logic alc_left;
		logic alc_right;
		logic signed [7:0] threshold_db;
		logic signed [7:0] ceiling_db;
		logic signed [7:0] floor_db;
		logic signed [7:0] noise_gate_db;
		logic noise_gate_active;
		logic gain_hold;
	} audio_settings_t;

	// times in ns and the clock
	localparam int CLK_PERIOD_NS = 40;
	localparam int HOLD_BASE_NS = 2670000;
	localparam int ATTACK_ALC_BASE_NS = 8400000;
	localparam int ATTACK_LIM_BASE_NS = 250000;
	localparam int DECAY_ALC_BASE_NS = 33500000;
	localparam int DECAY_LIM_BASE_NS = 1200000;
	localparam int TRANSIENT_BASE_NS = 62500;
	localparam int HOLD_BASE_CYCLES = (HOLD_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ATTACK_ALC_CYCLES = (ATTACK_ALC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ATTACK_LIM_CYCLES = (ATTACK_LIM_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DECAY_ALC_CYCLES = (DECAY_ALC_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int DECAY_LIM_CYCLES = (DECAY_LIM_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam logic [31:0] TRANSIENT_BASE_CYCLES =
		32'((TRANSIENT_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
	localparam logic [3:0] TIME_CODE_SAT = 4'ha;

endpackage : adc_ctrl_pkg

// [adc_ctrl_regs_monitor.sv]
// concurrent checks on the decoded settings of the converter control bank
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_regs_monitor
	import adc_ctrl_pkg::*;
#(
	parameter int HOLD_CYCLES = 4,
	parameter int ATTACK_ALC_BASE = 8,
	parameter int ATTACK_LIM_BASE = 2,
	parameter int DECAY_ALC_BASE = 16,
	parameter int DECAY_LIM_BASE = 3
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_b,
	// serial control pins and level detector
	input wire logic ctl_clock_pin,
	input wire logic ctl_data_pin,
	input wire logic ctl_latch_pin,
	input wire logic noise_gate_triggered,
	// outputs watched
	input wire audio_settings_t settings,
	input wire logic [31:0] hold_cycles,
	input wire logic [31:0] attack_cycles,
	input wire logic [31:0] decay_cycles,
	input wire logic [31:0] transient_cycles,
	input wire logic zero_cross_timeout_disable
);
	localparam logic [31:0] HOLD_MAX = 32'(HOLD_CYCLES) << 14;
	localparam logic [31:0] ATK_ALC_MAX = 32'(ATTACK_ALC_BASE) << 10;
	localparam logic [31:0] ATK_LIM_MAX = 32'(ATTACK_LIM_BASE) << 10;
	localparam logic [31:0] DCY_ALC_MAX = 32'(DECAY_ALC_BASE) << 10;
	localparam logic [31:0] DCY_LIM_MAX = 32'(DECAY_LIM_BASE) << 10;

	// all-zero outputs during the internal reset are not decoded values
	wire logic live = settings.word_bits != 6'h00;

	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (!rst_b);

	a_clock_oe_pair: assert property (settings.frame_clock_oe == settings.bit_clock_oe)
		else $error("frame and bit clock enables differ");
	a_midrail_route: assert property (settings.mux_to_midrail |-> settings.input_route == 4'h0)
		else $error("inputs routed while buffer powered down");
	a_gate_hold: assert property (settings.gain_hold |-> settings.noise_gate_active && !settings.limiter_mode)
		else $error("gain hold without an active gate");
	a_threshold_span: assert property (live |-> settings.threshold_db inside {[-16:-1]})
		else $error("threshold out of span");
	a_ceiling_steps: assert property (settings.ceiling_db inside {0, 4, 8, 12, 16, 20, 24})
		else $error("gain ceiling off its steps");
	a_floor_span: assert property (live |-> (settings.limiter_mode ? settings.floor_db inside {[-12:-3]}
		: settings.floor_db inside {-1, -5, -9, -13, -17, -21}))
		else $error("attenuation floor out of span");
	a_gate_level: assert property (live |-> settings.noise_gate_db inside {-78, -72, -66, -60, -54, -48, -42, -36})
		else $error("noise gate level off its steps");
	a_ratio_codes: assert property (settings.mclk_ratio inside {0, 256, 384, 512, 768})
		else $error("clock ratio not a listed value");
	a_word_sizes: assert property (settings.word_bits inside {0, 16, 20, 24, 32})
		else $error("word length not a listed value");
	a_window_mode: assert property (!settings.limiter_mode |-> transient_cycles == 32'h0)
		else $error("transient window outside limiter mode");
	a_attack_cap: assert property (attack_cycles <= (settings.limiter_mode ? ATK_LIM_MAX : ATK_ALC_MAX))
		else $error("attack time beyond saturation");
	a_decay_cap: assert property (decay_cycles <= (settings.limiter_mode ? DCY_LIM_MAX : DCY_ALC_MAX))
		else $error("decay time beyond saturation");
	a_hold_steps: assert property (hold_cycles == 32'h0 || (hold_cycles >= HOLD_CYCLES && hold_cycles <= HOLD_MAX))
		else $error("hold time off its steps");
	a_idle_stable: assert property ((live && ctl_latch_pin) [*8] |=> $stable(settings.left_gain_code)
		&& $stable(settings.audio_format) && $stable(settings.input_route))
		else $error("settings moved without a control write");
endmodule : adc_ctrl_regs_monitor

bind adc_ctrl_regs adc_ctrl_regs_monitor #(
	.HOLD_CYCLES(HOLD_CYCLES),
	.ATTACK_ALC_BASE(ATTACK_ALC_BASE),
	.ATTACK_LIM_BASE(ATTACK_LIM_BASE),
	.DECAY_ALC_BASE(DECAY_ALC_BASE),
	.DECAY_LIM_BASE(DECAY_LIM_BASE)
) i_mon (.clk_sys(clk_sys), .rst_b(rst_b), .ctl_clock_pin(ctl_clock_pin),
	.ctl_data_pin(ctl_data_pin), .ctl_latch_pin(ctl_latch_pin),
	.noise_gate_triggered(noise_gate_triggered), .settings(settings),
	.hold_cycles(hold_cycles), .attack_cycles(attack_cycles), .decay_cycles(decay_cycles),
	.transient_cycles(transient_cycles), .zero_cross_timeout_disable(zero_cross_timeout_disable));

`default_nettype wire

// [adc_ctrl_regs_tb_top.sv]
// self-checking testbench of the converter control bank
`timescale 1ns/1ps
`default_nettype none

module adc_ctrl_regs_tb_top
	import adc_ctrl_pkg::*;
;
	// small time bases keep the counts readable
	localparam int HOLD_P = 4;
	localparam int ATK_ALC_P = 8;
	localparam int ATK_LIM_P = 2;
	localparam int DCY_ALC_P = 16;
	localparam int DCY_LIM_P = 3;
	localparam logic [31:0] WB [4] = '{32'h10, 32'h14, 32'h18, 32'h20};
	localparam logic [31:0] RATIO [4] = '{32'h100, 32'h180, 32'h200, 32'h300};

	logic clk_sys = 1'b0;
	logic rst_b = 1'b0;
	logic ctl_clock_pin = 1'b0;
	logic ctl_data_pin = 1'b0;
	logic ctl_latch_pin = 1'b1;
	logic noise_gate_triggered = 1'b0;
	audio_settings_t settings;
	logic [31:0] hold_cycles;
	logic [31:0] attack_cycles;
	logic [31:0] decay_cycles;
	logic [31:0] transient_cycles;
	logic zero_cross_timeout_disable;
	int mismatches = 0;
	int total_checks = 0;

	always #20 clk_sys = ~clk_sys;

	adc_ctrl_regs #(.HOLD_CYCLES(HOLD_P), .ATTACK_ALC_BASE(ATK_ALC_P), .ATTACK_LIM_BASE(ATK_LIM_P),
		.DECAY_ALC_BASE(DCY_ALC_P), .DECAY_LIM_BASE(DCY_LIM_P)) i_dut (
		.clk_sys(clk_sys), .rst_b(rst_b), .ctl_clock_pin(ctl_clock_pin),
		.ctl_data_pin(ctl_data_pin), .ctl_latch_pin(ctl_latch_pin),
		.noise_gate_triggered(noise_gate_triggered), .settings(settings),
		.hold_cycles(hold_cycles), .attack_cycles(attack_cycles), .decay_cycles(decay_cycles),
		.transient_cycles(transient_cycles), .zero_cross_timeout_disable(zero_cross_timeout_disable));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		total_checks++;
		if (got !== exp) begin
			mismatches++;
			$display("BAD %s expected %h seen %h", what, exp, got);
		end
	endtask : chk

	// each pin level held well over the three-flop filter
	task automatic wr(input logic [6:0] a, input logic [8:0] d);
		logic [15:0] w;
		w = {a, d};
		@(negedge clk_sys) ctl_latch_pin = 1'b0;
		for (int i = 15; i >= 0; i--) begin
			ctl_data_pin = w[i];
			repeat (4) @(negedge clk_sys);
			ctl_clock_pin = 1'b1;
			repeat (5) @(negedge clk_sys);
			ctl_clock_pin = 1'b0;
			repeat (4) @(negedge clk_sys);
		end
		ctl_latch_pin = 1'b1;
		ctl_data_pin = ~w[0];
		repeat (14) @(negedge clk_sys);
	endtask : wr

	task automatic check_defaults;
		chk("format", 32'h2, 32'(settings.audio_format));
		chk("edge", 32'h0, 32'(settings.sample_on_falling));
		chk("word_bits", 32'h18, 32'(settings.word_bits));
		chk("ratio", 32'h100, 32'(settings.mclk_ratio));
		chk("frame_oe", 32'h0, 32'(settings.frame_clock_oe));
		chk("left_gain", 32'hcf, 32'(settings.left_gain_code));
		chk("right_gain", 32'hcf, 32'(settings.right_gain_code));
		chk("threshold", 32'hfb, {24'h0, settings.threshold_db});
		chk("ceiling", 32'h18, {24'h0, settings.ceiling_db});
		chk("limiter", 32'h1, 32'(settings.limiter_mode));
		chk("attack", 32'(ATK_LIM_P << 2), attack_cycles);
		chk("decay", 32'(DCY_LIM_P << 3), decay_cycles);
		chk("floor", 32'hfa, {24'h0, settings.floor_db});
		chk("window", TRANSIENT_BASE_CYCLES << 1, transient_cycles);
		chk("route", 32'h1, 32'(settings.input_route));
	endtask : check_defaults

	task automatic t_format;
		for (int i = 0; i < 4; i++) begin
			wr(ADDR_AUDIO_INTERFACE, {3'h0, 2'(i), i[0], 1'b1, 2'(i)});
			chk("format", 32'(i), 32'(settings.audio_format));
			chk("invert", 32'(i != 3), 32'(settings.frame_invert));
			chk("late", 32'(i == 3), 32'(settings.dsp_late));
			chk("edge", 32'(i[0]), 32'(settings.sample_on_falling));
			chk("word_bits", WB[i], 32'(settings.word_bits));
		end
	endtask : t_format

	task automatic t_master;
		for (int c = 2; c < 6; c++) begin
			wr(ADDR_MASTER_CLOCKING, {1'b1, 5'h0, 3'(c)});
			chk("ratio", RATIO[c - 2], 32'(settings.mclk_ratio));
			chk("frame_oe", 32'h1, 32'(settings.frame_clock_oe));
			chk("bit_oe", 32'h1, 32'(settings.bit_clock_oe));
		end
	endtask : t_master

	task automatic t_reset;
		wr(ADDR_ZERO_CROSS_TIMEOUT, 9'h008);
		wr(7'h16, 9'h000);
		chk("timeout_off", 32'h1, 32'(zero_cross_timeout_disable));
		wr(ADDR_REGISTER_RESET, 9'h155);
		check_defaults();
		chk("timeout_off", 32'h0, 32'(zero_cross_timeout_disable));
	endtask : t_reset

	task automatic t_power;
		wr(ADDR_POWERDOWN, 9'h041);
		wr(ADDR_INPUT_MIXER, 9'h005);
		chk("chip_pd", 32'h1, 32'(settings.all_powered_down));
		chk("midrail", 32'h1, 32'(settings.mux_to_midrail));
		chk("route", 32'h0, 32'(settings.input_route));
		wr(ADDR_POWERDOWN, 9'h000);
		chk("chip_pd", 32'h0, 32'(settings.all_powered_down));
		chk("route", 32'h5, 32'(settings.input_route));
	endtask : t_power

	task automatic t_gain;
		wr(ADDR_INPUT_MIXER, 9'h1c5);
		chk("left_mute", 32'h1, 32'(settings.left_mute));
		chk("right_mute", 32'h1, 32'(settings.right_mute));
		wr(ADDR_LEFT_GAIN, 9'h1a0);
		chk("left_gain", 32'ha0, 32'(settings.left_gain_code));
		chk("right_gain", 32'ha0, 32'(settings.right_gain_code));
		chk("left_zc", 32'h1, 32'(settings.left_zero_cross));
		chk("right_zc", 32'h0, 32'(settings.right_zero_cross));
		wr(ADDR_INPUT_MIXER, 9'h005);
		wr(ADDR_RIGHT_GAIN, 9'h033);
		chk("right_gain", 32'h33, 32'(settings.right_gain_code));
		chk("left_gain", 32'ha0, 32'(settings.left_gain_code));
		chk("left_mute", 32'h0, 32'(settings.left_mute));
	endtask : t_gain

	task automatic t_level;
		wr(ADDR_LEVEL_ONE, 9'h180);
		chk("alc_left", 32'h0, 32'(settings.alc_left));
		wr(ADDR_LEVEL_TWO, 9'h183);
		chk("run", 32'h1, 32'(settings.gain_control_run));
		chk("level_zc", 32'h1, 32'(settings.level_zero_cross));
		chk("alc_left", 32'h1, 32'(settings.alc_left));
		chk("alc_right", 32'h1, 32'(settings.alc_right));
		chk("hold", 32'(HOLD_P << 2), hold_cycles);
		chk("threshold", 32'hf0, {24'h0, settings.threshold_db});
		chk("ceiling", 32'h0, {24'h0, settings.ceiling_db});
		chk("floor", 32'hff, {24'h0, settings.floor_db});
		chk("window", 32'h0, transient_cycles);
		wr(ADDR_LEVEL_THREE, 9'h0ff);
		chk("attack", 32'(ATK_ALC_P << 10), attack_cycles);
		chk("decay", 32'(DCY_ALC_P << 10), decay_cycles);
		wr(ADDR_LIMITER, 9'h07f);
		chk("floor", 32'heb, {24'h0, settings.floor_db});
		wr(ADDR_NOISE_GATE, 9'h01d);
		chk("gate_db", 32'hdc, {24'h0, settings.noise_gate_db});
		chk("gate_on", 32'h1, 32'(settings.noise_gate_active));
		noise_gate_triggered = 1'b1;
		repeat (4) @(negedge clk_sys);
		chk("gain_hold", 32'h1, 32'(settings.gain_hold));
		noise_gate_triggered = 1'b0;
		wr(ADDR_LEVEL_ONE, 9'h080);
		chk("alc_right", 32'h1, 32'(settings.alc_right));
		chk("alc_left", 32'h0, 32'(settings.alc_left));
		wr(ADDR_LEVEL_ONE, 9'h100);
		chk("alc_left", 32'h1, 32'(settings.alc_left));
		chk("alc_right", 32'h0, 32'(settings.alc_right));
		wr(ADDR_LEVEL_TWO, 9'h000);
		chk("run", 32'h0, 32'(settings.gain_control_run));
		chk("alc_left", 32'h0, 32'(settings.alc_left));
	endtask : t_level

	task automatic summarize;
		if (mismatches == 0 && total_checks > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize

	// about 25 words of some 230 cycles each
	initial begin
		repeat (30000) @(posedge clk_sys);
		mismatches++;
		summarize();
	end

	initial begin
		repeat (10) @(negedge clk_sys);
		rst_b = 1'b1;
		repeat (10) @(negedge clk_sys);
		check_defaults();
		t_format();
		t_master();
		t_reset();
		t_power();
		t_gain();
		t_level();
		summarize();
	end
endmodule : adc_ctrl_regs_tb_top

`default_nettype wire
